// ### src/spi_dma_length_clock_format.sv
// spi top: apb register file, word queues, dma handshakes and shift engine
`timescale 1ns/1ps
// Operation
// - tx dma request while enabled and tx empty; done clears the flag
// - rx dma request while enabled and rx full; done clears the flag
// - fifo mode takes eight bytes or four words per tx request
// - fifo mode lets one rx request read eight bytes or four words
// - word length is 8 bits when clear, 16 bits when set
// - narrow mode uses low bytes only; high reads zero, writes ignored
// - wide reads freeze both data bytes until the other is read
// - wide data writes go out together once both bytes arrive
// - wide match writes load together; match reads are direct
// - master length change aborts, idles, empties queues, clears rx full and sets tx empty
// - polarity inverts clock; phase picks one of two data timings
// - phase one master select falls half clock early, rises at end
// - phase one slave drives miso once selected, undefined before edge
// - phase one shifts on odd edges and samples on even edges
// - phase one master sends queued data back to back, select low
// - phase zero master select at bit one, rises half clock late
// - phase zero slave drives first bit when selected; sample odd edges
// - word ends after 8 or 16 shifts; data stored, rx full set
module spi_dma_length_clock_format
	import spi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_dma_req,
	input wire logic tx_dma_done,
	output logic rx_dma_req,
	input wire logic rx_dma_done,
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic slave_select_in_n,
	output logic slave_select_out_n,
	output logic slave_select_oe
);
	spi_engine_if eif();
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic txe_q, txe_d, rxf_q, rxf_d;
	logic [15:0] tq_mem_q [QDEPTH];
	logic [15:0] tq_mem_d [QDEPTH];
	logic [15:0] rq_mem_q [QDEPTH];
	logic [15:0] rq_mem_d [QDEPTH];
	logic [2:0] tq_wp_q, tq_wp_d, tq_rp_q, tq_rp_d, rq_wp_q, rq_wp_d, rq_rp_q, rq_rp_d;
	logic [3:0] tq_cnt_q, tq_cnt_d, rq_cnt_q, rq_cnt_d, limit;
	logic [15:0] wbuf_q, wbuf_d, mbuf_q, mbuf_d, match_q, match_d, hold_q, hold_d;
	logic whi_q, whi_d, wlo_q, wlo_d, mhi_q, mhi_d, mlo_q, mlo_d;
	logic hold_v_q, hold_v_d, hold_hi_q, hold_hi_d;
	logic [31:0] prdata_q, prdata_d;
	logic setup, acc_wr, acc_rd, mapped;
	logic hit_ctrl, hit_stat, hit_dh, hit_dl, hit_mh, hit_ml;
	logic wide, abort, push, pop, rx_ok;
	logic [15:0] push_word, rx_head, rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states, so read data is captured in the setup cycle
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pwrite;
	assign acc_rd = psel && penable && !pwrite;
	assign hit_ctrl = (paddr == CTRL_OFS);
	assign hit_stat = (paddr == STATUS_OFS);
	assign hit_dh = (paddr == DATA_HI_OFS);
	assign hit_dl = (paddr == DATA_LO_OFS);
	assign hit_mh = (paddr == MATCH_HI_OFS);
	assign hit_ml = (paddr == MATCH_LO_OFS);
	assign mapped = hit_ctrl || hit_stat || hit_dh || hit_dl || hit_mh || hit_ml;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_q;

	assign wide = ctrl_q[WIDE_BIT];
	assign limit = !ctrl_q[FIFO_BIT] ? QLIM_ONE : (wide ? QLIM_WIDE : QLIM_NARROW);
	assign rx_head = rq_mem_q[rq_rp_q];
	assign rd_word = hold_v_q ? hold_q : rx_head;

	assign tx_dma_req = ctrl_q[TX_DMA_BIT] && ctrl_q[EN_BIT] && txe_q;
	assign rx_dma_req = ctrl_q[RX_DMA_BIT] && ctrl_q[EN_BIT] && rxf_q;

	////////////////////////////////////////////////////////////////////////////////
	// engine hookup; select output needs both the output and fault enables
	assign eif.enable = ctrl_q[EN_BIT];
	assign eif.master = ctrl_q[MASTER_BIT];
	assign eif.polarity = ctrl_q[POL_BIT];
	assign eif.phase = ctrl_q[PHASE_BIT];
	assign eif.lsb_first = ctrl_q[LSB_BIT];
	assign eif.wide = wide;
	assign eif.ss_drive = ctrl_q[SSOUT_BIT] && ctrl_q[FAULTEN_BIT];
	assign eif.abort = abort;
	assign eif.have_data = (tq_cnt_q != 4'h0);
	assign eif.tx_word = tq_mem_q[tq_rp_q];

	spi_shift_engine u_engine (
		.clk(clk),
		.rst(rst),
		.eif(eif.eng),
		.serial_clock_in(serial_clock_in),
		.serial_clock_out(serial_clock_out),
		.serial_clock_oe(serial_clock_oe),
		.mosi_in(mosi_in),
		.mosi_out(mosi_out),
		.mosi_oe(mosi_oe),
		.miso_in(miso_in),
		.miso_out(miso_out),
		.miso_oe(miso_oe),
		.slave_select_in_n(slave_select_in_n),
		.slave_select_out_n(slave_select_out_n),
		.slave_select_oe(slave_select_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register writes, byte pairing and read side effects
	always_comb
	begin
		ctrl_d = ctrl_q;
		wbuf_d = wbuf_q;
		whi_d = whi_q;
		wlo_d = wlo_q;
		mbuf_d = mbuf_q;
		mhi_d = mhi_q;
		mlo_d = mlo_q;
		match_d = match_q;
		hold_d = hold_q;
		hold_v_d = hold_v_q;
		hold_hi_d = hold_hi_q;
		prdata_d = prdata_q;
		abort = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_word = 16'h0000;
		if (acc_wr && hit_ctrl)
		begin
			ctrl_d = pwdata[CTRL_W-1:0];
			abort = ctrl_q[MASTER_BIT] && (pwdata[WIDE_BIT] != wide);
		end
		if (acc_wr && hit_dl && !wide)
		begin
			push = 1'b1;
			push_word = {8'h00, pwdata[7:0]};
		end
		if (acc_wr && wide && (hit_dh || hit_dl))
		begin
			if (hit_dh)
				wbuf_d[15:8] = pwdata[7:0];
			else
				wbuf_d[7:0] = pwdata[7:0];
			whi_d = whi_q || hit_dh;
			wlo_d = wlo_q || hit_dl;
			if (whi_d && wlo_d)
			begin
				push = 1'b1;
				push_word = wbuf_d;
				whi_d = 1'b0;
				wlo_d = 1'b0;
			end
		end
		if (acc_wr && hit_ml && !wide)
			match_d = {8'h00, pwdata[7:0]};
		if (acc_wr && wide && (hit_mh || hit_ml))
		begin
			if (hit_mh)
				mbuf_d[15:8] = pwdata[7:0];
			else
				mbuf_d[7:0] = pwdata[7:0];
			mhi_d = mhi_q || hit_mh;
			mlo_d = mlo_q || hit_ml;
			if (mhi_d && mlo_d)
			begin
				match_d = mbuf_d;
				mhi_d = 1'b0;
				mlo_d = 1'b0;
			end
		end
		if (acc_rd && wide && (hit_dh || hit_dl))
		begin
			if (!hold_v_q)
			begin
				hold_d = rx_head;
				hold_v_d = 1'b1;
				hold_hi_d = hit_dh;
			end
			else if (hold_hi_q != hit_dh)
			begin
				hold_v_d = 1'b0;
				pop = 1'b1;
			end
		end
		if (acc_rd && !wide && hit_dl)
			pop = 1'b1;
		// read data is latched in setup; high bytes stay zero in narrow mode
		if (setup)
		begin
			prdata_d = 32'h0000_0000;
			if (hit_ctrl)
				prdata_d[CTRL_W-1:0] = ctrl_q;
			if (hit_stat)
			begin
				prdata_d[RXF_BIT] = rxf_q;
				prdata_d[TXE_BIT] = txe_q;
				prdata_d[BUSY_BIT] = eif.busy;
			end
			if (hit_dh && wide)
				prdata_d[7:0] = rd_word[15:8];
			if (hit_dl)
				prdata_d[7:0] = rd_word[7:0];
			if (hit_mh && wide)
				prdata_d[7:0] = match_q[15:8];
			if (hit_ml)
				prdata_d[7:0] = match_q[7:0];
		end
		if (abort)
		begin
			whi_d = 1'b0;
			wlo_d = 1'b0;
			hold_v_d = 1'b0;
			push = 1'b0;
			pop = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			wbuf_q <= 16'h0000;
			whi_q <= 1'b0;
			wlo_q <= 1'b0;
			mbuf_q <= 16'h0000;
			mhi_q <= 1'b0;
			mlo_q <= 1'b0;
			match_q <= 16'h0000;
			hold_q <= 16'h0000;
			hold_v_q <= 1'b0;
			hold_hi_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			wbuf_q <= wbuf_d;
			whi_q <= whi_d;
			wlo_q <= wlo_d;
			mbuf_q <= mbuf_d;
			mhi_q <= mhi_d;
			mlo_q <= mlo_d;
			match_q <= match_d;
			hold_q <= hold_d;
			hold_v_q <= hold_v_d;
			hold_hi_q <= hold_hi_d;
			prdata_q <= prdata_d;
		end

	////////////////////////////////////////////////////////////////////////////////
	// transmit queue; a write beyond the burst depth is dropped, not stalled
	always_comb
	begin
		tq_mem_d = tq_mem_q;
		tq_wp_d = tq_wp_q;
		tq_rp_d = tq_rp_q;
		tq_cnt_d = tq_cnt_q;
		if (push && (tq_cnt_q < limit))
		begin
			tq_mem_d[tq_wp_q] = push_word;
			tq_wp_d = tq_wp_q + 3'h1;
			tq_cnt_d = tq_cnt_d + 4'h1;
		end
		if (eif.take)
		begin
			tq_rp_d = tq_rp_q + 3'h1;
			tq_cnt_d = tq_cnt_d - 4'h1;
		end
		if (abort)
		begin
			tq_wp_d = 3'h0;
			tq_rp_d = 3'h0;
			tq_cnt_d = 4'h0;
		end
		txe_d = abort || (eif.take && (tq_cnt_d == 4'h0)) || (txe_q && !tx_dma_done && !push);
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			tq_mem_q <= '{default: 16'h0000};
			tq_wp_q <= 3'h0;
			tq_rp_q <= 3'h0;
			tq_cnt_q <= 4'h0;
			txe_q <= 1'b1;
		end
		else
		begin
			tq_mem_q <= tq_mem_d;
			tq_wp_q <= tq_wp_d;
			tq_rp_q <= tq_rp_d;
			tq_cnt_q <= tq_cnt_d;
			txe_q <= txe_d;
		end

	////////////////////////////////////////////////////////////////////////////////
	// receive queue; a word arriving when the queue is full is lost
	always_comb
	begin
		rq_mem_d = rq_mem_q;
		rq_wp_d = rq_wp_q;
		rq_rp_d = rq_rp_q;
		rq_cnt_d = rq_cnt_q;
		rx_ok = eif.done && (rq_cnt_q < limit) && !abort;
		if (rx_ok)
		begin
			rq_mem_d[rq_wp_q] = eif.rx_word;
			rq_wp_d = rq_wp_q + 3'h1;
			rq_cnt_d = rq_cnt_d + 4'h1;
		end
		if (pop && (rq_cnt_q != 4'h0))
		begin
			rq_rp_d = rq_rp_q + 3'h1;
			rq_cnt_d = rq_cnt_d - 4'h1;
		end
		if (abort)
		begin
			rq_wp_d = 3'h0;
			rq_rp_d = 3'h0;
			rq_cnt_d = 4'h0;
		end
		rxf_d = rx_ok || (rxf_q && !abort && !rx_dma_done && !(pop && (rq_cnt_d == 4'h0)));
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			rq_mem_q <= '{default: 16'h0000};
			rq_wp_q <= 3'h0;
			rq_rp_q <= 3'h0;
			rq_cnt_q <= 4'h0;
			rxf_q <= 1'b0;
		end
		else
		begin
			rq_mem_q <= rq_mem_d;
			rq_wp_q <= rq_wp_d;
			rq_rp_q <= rq_rp_d;
			rq_cnt_q <= rq_cnt_d;
			rxf_q <= rxf_d;
		end
endmodule // spi_dma_length_clock_format

// ### src/spi_pkg.sv
// constants shared by the spi dma, word length and clock format block
package spi_pkg;
	// register byte offsets on the apb
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] DATA_HI_OFS = 8'h08;
	localparam logic [7:0] DATA_LO_OFS = 8'h0C;
	localparam logic [7:0] MATCH_HI_OFS = 8'h10;
	localparam logic [7:0] MATCH_LO_OFS = 8'h14;
	// control register layout
	localparam int CTRL_W = 11;
	localparam logic [10:0] CTRL_RST = 11'h000;
	localparam int EN_BIT = 0;
	localparam int MASTER_BIT = 1;
	localparam int POL_BIT = 2;
	localparam int PHASE_BIT = 3;
	localparam int LSB_BIT = 4;
	localparam int SSOUT_BIT = 5;
	localparam int FAULTEN_BIT = 6;
	localparam int WIDE_BIT = 7;
	localparam int FIFO_BIT = 8;
	localparam int TX_DMA_BIT = 9;
	localparam int RX_DMA_BIT = 10;
	// status register layout
	localparam int RXF_BIT = 0;
	localparam int TXE_BIT = 1;
	localparam int BUSY_BIT = 2;
	// queue depth and burst limits in words
	localparam int QDEPTH = 8;
	localparam logic [3:0] QLIM_ONE = 4'h1;
	localparam logic [3:0] QLIM_WIDE = 4'h4;
	localparam logic [3:0] QLIM_NARROW = 4'h8;
	// serial clock edges per word
	localparam logic [5:0] EDGES_NARROW = 6'h10;
	localparam logic [5:0] EDGES_WIDE = 6'h20;
	// master serial clock half period
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCK_HALF_NS = 80;
	localparam int HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1);
	// synchroniser reset: select input idles high
	localparam logic [3:0] SYNC_RST = 4'h8;
	typedef enum logic [1:0] {M_IDLE = 2'b00, M_SHIFT = 2'b01, M_TRAIL = 2'b11} mstate_e;
endpackage

// ### src/spi_engine_if.sv
// signals between the register file and the serial shift engine
`timescale 1ns/1ps
interface spi_engine_if;
	logic enable, master, polarity, phase, lsb_first, wide, ss_drive, abort, have_data;
	logic take, done, busy;
	logic [15:0] tx_word, rx_word;
	modport ctrl (output enable, master, polarity, phase, lsb_first, wide, ss_drive, abort,
		have_data, tx_word, input take, done, busy, rx_word);
	modport eng (input enable, master, polarity, phase, lsb_first, wide, ss_drive, abort,
		have_data, tx_word, output take, done, busy, rx_word);
endinterface

// ### src/spi_shift_engine.sv
// serial shift engine: master clocking, slave edge tracking, four clock formats
`timescale 1ns/1ps
module spi_shift_engine
	import spi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	spi_engine_if.eng eif,
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic slave_select_in_n,
	output logic slave_select_out_n,
	output logic slave_select_oe
);
	mstate_e st_q, st_d;
	logic [3:0] s1_q, s2_q;
	logic [7:0] tmr_q, tmr_d;
	logic [5:0] edge_q, edge_d, nedge;
	logic [15:0] sr_q, sr_d, rx_q, rx_d, fin;
	logic samp_q, samp_d, lvl_q, lvl_d, ss_q, ss_d, load_q, load_d, done_q, done_d;
	logic prev_q, ev, last, din, outbit;

	// insert the received bit at the far end of the word
	function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
		input logic w, input logic lsbf);
		if (!lsbf)
			return {v[14:0], b};
		return w ? {b, v[15:1]} : {8'h00, b, v[7:1]};
	endfunction

	assign outbit = eif.lsb_first ? sr_q[0] : (eif.wide ? sr_q[15] : sr_q[7]);
	assign din = eif.master ? s2_q[2] : s2_q[1];
	assign eif.done = done_q;
	assign eif.rx_word = rx_q;
	assign eif.busy = (st_q != M_IDLE) || load_q;
	assign serial_clock_out = eif.polarity ^ lvl_q;
	assign serial_clock_oe = eif.enable && eif.master;
	assign mosi_out = outbit;
	assign mosi_oe = eif.enable && eif.master;
	assign miso_out = outbit;
	assign miso_oe = eif.enable && !eif.master && !s2_q[3];
	assign slave_select_out_n = ss_q;
	assign slave_select_oe = eif.enable && eif.master && eif.ss_drive;

	////////////////////////////////////////////////////////////////////////////////
	// pins cross into clk through two flops; edge detection looks only at the second
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			prev_q <= 1'b0;
		end
		else
		begin
			s1_q <= {slave_select_in_n, miso_in, mosi_in, serial_clock_in};
			s2_q <= s1_q;
			prev_q <= s2_q[0];
		end

	////////////////////////////////////////////////////////////////////////////////
	// one engine serves both roles; an edge is a master timer expiry or a slave clock change
	always_comb
	begin
		st_d = st_q;
		tmr_d = tmr_q;
		edge_d = edge_q;
		sr_d = sr_q;
		samp_d = samp_q;
		lvl_d = lvl_q;
		ss_d = ss_q;
		load_d = load_q;
		rx_d = rx_q;
		done_d = 1'b0;
		eif.take = 1'b0;
		ev = 1'b0;
		last = 1'b0;
		fin = sr_q;
		nedge = edge_q + 6'h01;
		if (eif.master)
		begin
			unique case (st_q)
				M_IDLE:
					if (eif.have_data)
					begin
						eif.take = 1'b1;
						sr_d = eif.tx_word;
						ss_d = 1'b0;
						tmr_d = HALF_LOAD;
						edge_d = 6'h00;
						st_d = M_SHIFT;
					end
				M_SHIFT:
					if (tmr_q == 8'h00)
					begin
						ev = 1'b1;
						tmr_d = HALF_LOAD;
						lvl_d = !lvl_q;
					end
					else
						tmr_d = tmr_q - 8'h01;
				M_TRAIL:
					if (tmr_q == 8'h00)
					begin
						ss_d = 1'b1;
						st_d = M_IDLE;
					end
					else
						tmr_d = tmr_q - 8'h01;
				default:
					st_d = M_IDLE;
			endcase
		end
		else if (s2_q[3])
		begin
			edge_d = 6'h00;
			load_d = 1'b0;
		end
		else if (!load_q)
		begin
			eif.take = eif.have_data;
			sr_d = eif.have_data ? eif.tx_word : 16'h0000;
			load_d = 1'b1;
		end
		else
			ev = (s2_q[0] != prev_q);
		if (ev)
		begin
			edge_d = nedge;
			last = (nedge == (eif.wide ? EDGES_WIDE : EDGES_NARROW));
			if (nedge[0] != eif.phase)
				samp_d = din;
			else if (nedge != 6'h01)
				fin = shift_in(sr_q, samp_q, eif.wide, eif.lsb_first);
			if (last && eif.phase)
				fin = shift_in(sr_q, din, eif.wide, eif.lsb_first);
			sr_d = fin;
			if (last)
			begin
				done_d = 1'b1;
				rx_d = eif.wide ? fin : {8'h00, fin[7:0]};
				edge_d = 6'h00;
				load_d = 1'b0;
				if (eif.master && eif.phase && eif.have_data)
				begin
					eif.take = 1'b1;
					sr_d = eif.tx_word;
				end
				else if (eif.master)
					st_d = M_TRAIL;
			end
		end
		if (eif.abort || !eif.enable)
		begin
			st_d = M_IDLE;
			ss_d = 1'b1;
			lvl_d = 1'b0;
			edge_d = 6'h00;
			load_d = 1'b0;
			done_d = 1'b0;
			eif.take = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			st_q <= M_IDLE;
			tmr_q <= 8'h00;
			edge_q <= 6'h00;
			sr_q <= 16'h0000;
			rx_q <= 16'h0000;
			samp_q <= 1'b0;
			lvl_q <= 1'b0;
			ss_q <= 1'b1;
			load_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			edge_q <= edge_d;
			sr_q <= sr_d;
			rx_q <= rx_d;
			samp_q <= samp_d;
			lvl_q <= lvl_d;
			ss_q <= ss_d;
			load_q <= load_d;
			done_q <= done_d;
		end
endmodule // spi_shift_engine

// ### verification/spi_dma_length_clock_format_assertions.sv
// port-level checks for the spi dma, word length and clock format block
`timescale 1ns/1ps
module spi_port_assertions
	import spi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic tx_dma_req,
	input wire logic tx_dma_done,
	input wire logic rx_dma_req,
	input wire logic rx_dma_done,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic slave_select_out_n
);
	logic [10:0] ctrl_q, ctrl_d;
	logic [8:0] edges_q, edges_d;
	logic [2:0] quiet_q, quiet_d;
	logic sclk_q, wr, moved;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// shadow of control writes; clock edges per frame and idle time since the last edge
	assign wr = psel && penable && pwrite;
	assign moved = serial_clock_out != sclk_q;
	always_comb
	begin
		ctrl_d = (wr && paddr == CTRL_OFS) ? pwdata[10:0] : ctrl_q;
		edges_d = slave_select_out_n ? 9'h000 : edges_q + 9'(moved);
		quiet_d = moved ? 3'h0 : quiet_q + 3'(quiet_q != 3'h7); // saturates, only short gaps matter
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			edges_q <= 9'h000;
			quiet_q <= 3'h0;
			sclk_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			edges_q <= edges_d;
			quiet_q <= quiet_d;
			sclk_q <= serial_clock_out;
		end
	end
	////////////////////////////////////////////////////////////
	a_tx_req_gate: assert property (
		!(ctrl_q[EN_BIT] && ctrl_q[TX_DMA_BIT]) |-> !tx_dma_req)
		else $error("tx request without its enables");
	a_rx_req_gate: assert property (
		!(ctrl_q[EN_BIT] && ctrl_q[RX_DMA_BIT]) |-> !rx_dma_req)
		else $error("rx request without its enables");
	a_tx_req_drop: assert property (
		tx_dma_done && tx_dma_req && !wr |=> !tx_dma_req)
		else $error("tx request outlived its done");
	a_rx_req_drop: assert property (
		rx_dma_done && rx_dma_req |=> !rx_dma_req)
		else $error("rx request outlived its done");
	a_narrow_high: assert property (
		psel && penable && !pwrite && !ctrl_q[WIDE_BIT]
		&& (paddr == DATA_HI_OFS || paddr == MATCH_HI_OFS) |-> prdata == 32'h0)
		else $error("narrow high byte read not zero");
	a_clock_idle: assert property (
		serial_clock_oe && slave_select_out_n && $past(slave_select_out_n) && $stable(ctrl_q)
		|-> serial_clock_out == ctrl_q[POL_BIT])
		else $error("idle serial clock level wrong");
	a_word_edges: assert property (
		$rose(slave_select_out_n) && serial_clock_oe |-> edges_q != 9'h000
		&& (ctrl_q[WIDE_BIT] ? edges_q[4:0] == 5'h00 : edges_q[3:0] == 4'h0))
		else $error("frame edge count not whole words");
	a_select_lead: assert property (
		$fell(slave_select_out_n) |-> $stable(serial_clock_out)[*3] ##[1:6] $changed(serial_clock_out))
		else $error("first clock edge not half a cycle after select");
	a_select_trail: assert property (
		$rose(slave_select_out_n) |-> quiet_q >= 3'h2)
		else $error("select released too soon after last edge");
	a_length_abort: assert property (
		wr && paddr == CTRL_OFS && pwdata[MASTER_BIT] && ctrl_q[MASTER_BIT]
		&& pwdata[WIDE_BIT] != ctrl_q[WIDE_BIT] |-> ##[1:2] (slave_select_out_n && !rx_dma_req))
		else $error("length change did not idle and clear");
endmodule // spi_port_assertions

// ### verification/spi_remote_slave.sv
// behavioural remote serial slave on the far side of the pins
`timescale 1ns/1ps
module spi_remote_slave
(
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic clock_polarity,
	input wire logic clock_phase,
	input wire logic [15:0] resp,
	output logic miso,
	output logic [31:0] rx_q,
	output int frames
);
	logic [31:0] sh_q;
	logic first_q;
	initial
	begin
		rx_q = 32'h0;
		sh_q = 32'h0;
		first_q = 1'b0;
		frames = 0;
	end
	always @(negedge ss_n)
	begin
		sh_q <= {resp, ~resp}; // second word differs so coherent reads can be told apart
		first_q <= clock_phase;
		frames <= frames + 1;
	end
	always @(sclk)
	begin
		if (!ss_n && ((sclk != clock_polarity) ^ clock_phase))
			rx_q <= {rx_q[30:0], mosi};
		else if (!ss_n && first_q)
			first_q <= 1'b0;
		else if (!ss_n)
			sh_q <= {sh_q[30:0], 1'b0};
	end
	assign miso = (ss_n || first_q) ? ~sh_q[31] : sh_q[31];
endmodule // spi_remote_slave

// ### verification/spi_dma_length_clock_format_bench.sv
// self-checking bench for the spi dma, word length and clock format block
`timescale 1ns/1ps
module spi_dma_length_clock_format_bench
	import spi_pkg::*;
;
	localparam logic [15:0] RESP = 16'hC3A6;
	localparam logic [15:0] NRESP = ~RESP;
	localparam logic [31:0] BASE = 32'h00000063; // enable, master, select out, fault enable
	logic clk, rst, psel, penable, pwrite, tx_dma_done, rx_dma_done, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, peer_rx;
	logic pready, pslverr, tx_dma_req, rx_dma_req, m_pol, m_pha, peer_miso;
	logic serial_clock_in, serial_clock_out, serial_clock_oe, mosi_in, mosi_out, mosi_oe;
	logic miso_in, miso_out, miso_oe, slave_select_in_n, slave_select_out_n, slave_select_oe;
	logic m_sclk, ms_n, m_mosi; // remote master pins for the slave scenario
	int frames, errors, num_checks, n;
	// pad levels: remote master pins idle with select and mosi high, clock low
	assign serial_clock_in = serial_clock_oe ? serial_clock_out : m_sclk;
	assign slave_select_in_n = slave_select_oe ? slave_select_out_n : ms_n;
	assign mosi_in = mosi_oe ? mosi_out : m_mosi;
	assign miso_in = miso_oe ? miso_out : peer_miso;
	spi_dma_length_clock_format dut (.*);
	spi_remote_slave peer (.sclk(serial_clock_in), .ss_n(slave_select_in_n), .mosi(mosi_in),
		.clock_polarity(m_pol), .clock_phase(m_pha), .resp(RESP), .miso(peer_miso), .rx_q(peer_rx), .frames(frames));
	////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
			@(posedge clk) k++;
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// waits for a select frame to open and close, bounded
	task automatic wait_frame;
		int k;
		k = 0;
		while (slave_select_out_n !== 1'b0 && k < 40) @(posedge clk) k++;
		while (slave_select_out_n !== 1'b1 && k < 700) @(posedge clk) k++;
		repeat (6) @(posedge clk);
	endtask
	task automatic stop_test;
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status reset", 32'h00000002, rd);
		chk("tx req", 32'h0, 32'(tx_dma_req));
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
	endtask
	task automatic t_narrow;
		apb(1'b1, CTRL_OFS, BASE | 32'h00000400);
		apb(1'b1, DATA_HI_OFS, 32'h00000077);
		apb(1'b0, DATA_HI_OFS, 32'h0);
		chk("narrow high", 32'h0, rd);
		n = frames;
		apb(1'b1, DATA_LO_OFS, 32'h000000A5);
		wait_frame;
		chk("frames", 32'(n + 1), 32'(frames));
		chk("mosi byte", 32'h000000A5, {24'h0, peer_rx[7:0]});
		chk("rx req", 32'h1, 32'(rx_dma_req));
		@(posedge clk) rx_dma_done <= 1'b1;
		@(posedge clk) rx_dma_done <= 1'b0;
		@(negedge clk) chk("rx req drop", 32'h0, 32'(rx_dma_req));
		apb(1'b0, DATA_LO_OFS, 32'h0);
		chk("miso byte", {24'h0, RESP[15:8]}, rd);
	endtask
	task automatic t_txdma;
		apb(1'b1, CTRL_OFS, BASE | 32'h00000600);
		@(negedge clk) chk("tx req", 32'h1, 32'(tx_dma_req));
		@(posedge clk) tx_dma_done <= 1'b1;
		@(posedge clk) tx_dma_done <= 1'b0;
		@(negedge clk) chk("tx req drop", 32'h0, 32'(tx_dma_req));
		apb(1'b1, DATA_LO_OFS, 32'h0000003C);
		n = 0;
		while (tx_dma_req !== 1'b1 && n < 10) @(posedge clk) n++;
		chk("tx req again", 32'h1, 32'(tx_dma_req));
		wait_frame;
		chk("mosi byte", 32'h0000003C, {24'h0, peer_rx[7:0]});
	endtask
	task automatic t_wide;
		m_pol = 1'b1;
		m_pha = 1'b1;
		// status read before data; the length change abort has cleared rx full here
		apb(1'b1, CTRL_OFS, 32'h000005EF);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status after abort", 32'h00000002, rd);
		n = frames;
		apb(1'b1, DATA_HI_OFS, 32'h00000012);
		apb(1'b1, DATA_LO_OFS, 32'h00000034);
		apb(1'b1, DATA_LO_OFS, 32'h00000078);
		apb(1'b1, DATA_HI_OFS, 32'h00000056);
		wait_frame;
		chk("one frame", 32'(n + 1), 32'(frames));
		chk("mosi words", 32'h12345678, peer_rx);
		apb(1'b0, DATA_HI_OFS, 32'h0);
		chk("rx hi", {24'h0, RESP[15:8]}, rd);
		apb(1'b0, DATA_HI_OFS, 32'h0);
		chk("rx hi held", {24'h0, RESP[15:8]}, rd);
		apb(1'b0, DATA_LO_OFS, 32'h0);
		chk("rx lo", {24'h0, RESP[7:0]}, rd);
		apb(1'b0, DATA_LO_OFS, 32'h0);
		chk("rx lo 2", {24'h0, NRESP[7:0]}, rd);
		apb(1'b0, DATA_HI_OFS, 32'h0);
		chk("rx hi 2", {24'h0, NRESP[15:8]}, rd);
		apb(1'b1, MATCH_HI_OFS, 32'h000000AB);
		apb(1'b0, MATCH_HI_OFS, 32'h0);
		chk("match half", 32'h0, rd);
		apb(1'b1, MATCH_LO_OFS, 32'h000000CD);
		apb(1'b0, MATCH_HI_OFS, 32'h0);
		chk("match hi", 32'h000000AB, rd);
		apb(1'b0, MATCH_LO_OFS, 32'h0);
		chk("match lo", 32'h000000CD, rd);
	endtask
	// remote master drives a phase 0 byte into the block as slave
	task automatic t_slave;
		logic [7:0] b, got;
		b = 8'hC5;
		got = 8'h00;
		apb(1'b1, CTRL_OFS, 32'h00000001); // length set once for slave use
		apb(1'b1, DATA_LO_OFS, 32'h0000005A);
		@(posedge clk) ms_n <= 1'b0;
		m_mosi <= b[7];
		for (int i = 0; i < 8; i++)
		begin
			repeat (8) @(posedge clk);
			m_sclk <= 1'b1;
			got = {got[6:0], miso_in};
			repeat (8) @(posedge clk);
			m_sclk <= 1'b0;
			b = b << 1;
			m_mosi <= b[7];
		end
		repeat (8) @(posedge clk);
		ms_n <= 1'b1;
		chk("slave miso", 32'h0000005A, {24'h0, got});
		apb(1'b0, DATA_LO_OFS, 32'h0);
		chk("slave mosi", 32'h000000C5, rd);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// watchdog: whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test;
	end
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, tx_dma_done, rx_dma_done, m_pol, m_pha} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		{m_sclk, ms_n, m_mosi} = 3'b011;
		errors = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_narrow;
		t_txdma;
		t_wide;
		t_slave;
		stop_test;
	end
endmodule // spi_dma_length_clock_format_bench
bind spi_dma_length_clock_format spi_port_assertions sva (.*);
